/* File: afe_pkg.sv */
package afe_pkg;

  // Serial control word
  localparam int SER_BITS = 11;
  localparam logic [3:0] SER_COUNT = 4'hB;
  localparam int SEL_MSB = 10;
  localparam int SEL_LSB = 8;
  localparam int DATA_MSB = 7;

  // Register select codes
  localparam logic [2:0] SEL_RED_GAIN = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h6;
  localparam int NUM_CHAN_REGS = 6;

  // Reset values
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] OFFS_RST = 8'h40;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Gain field sits in the top six bits of a gain register
  localparam int GAIN_MSB = 7;
  localparam int GAIN_LSB = 2;

  // Mode register fields
  localparam int MODE_PD_BIT = 7;
  localparam int MODE_DRST_BIT = 6;
  localparam int MODE_TOPREF_BIT = 5;
  localparam int MODE_DCREF_BIT = 4;
  localparam int MODE_AC_BIT = 3;
  localparam int MODE_INV_BIT = 2;
  localparam int MODE_CFG_MSB = 1;
  localparam int MODE_CFG_LSB = 0;

  // Output latency in conversion clock cycles
  localparam int LAT_LONG = 8;
  localparam int LAT_PIXEL = 6;
  localparam int PIPE_DEPTH = 8;

  typedef enum logic [1:0] {
    AFE_CFG_SINGLE,
    AFE_CFG_PIX_SINGLE,
    AFE_CFG_PIX_TRIPLE,
    AFE_CFG_LINE_TRIPLE
  } afe_cfg_t;

  typedef enum logic [1:0] {
    AFE_CH_RED,
    AFE_CH_GRN,
    AFE_CH_BLU
  } afe_chan_t;

endpackage

/* File: afe_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module afe_sync #(
  parameter int WIDTH = 6
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: afe_serial_load.sv */
`timescale 1ns/1ps
`default_nettype none
module afe_serial_load (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_load,
  input wire logic i_sclk,
  input wire logic i_sdata,
  output logic o_wr,
  output logic [2:0] o_sel,
  output logic [7:0] o_data
);
  import afe_pkg::*;

  logic load_q;
  logic sclk_q;
  logic armed;
  logic [3:0] cnt;
  logic [SER_BITS-1:0] shreg;
  logic load_fall;
  logic load_rise;
  logic sclk_rise;

  assign load_fall = load_q & ~i_load;
  assign load_rise = ~load_q & i_load;
  assign sclk_rise = ~sclk_q & i_sclk;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      load_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      load_q <= i_load;
      sclk_q <= i_sclk;
    end
  end

  // Load low opens a word, only while the port is enabled
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_enable) begin
      armed <= 1'b0;
      cnt <= 4'h0;
      shreg <= '0;
    end else if (load_fall) begin
      armed <= 1'b1;
      cnt <= 4'h0;
    end else if (load_rise) begin
      armed <= 1'b0;
    end else if (armed && sclk_rise && cnt < SER_COUNT) begin
      shreg <= {shreg[SER_BITS-2:0], i_sdata};
      cnt <= cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wr <= 1'b0;
      o_sel <= 3'h0;
      o_data <= 8'h00;
    end else begin
      o_wr <= i_enable && armed && load_rise && cnt == SER_COUNT;
      o_sel <= shreg[SEL_MSB:SEL_LSB];
      o_data <= shreg[DATA_MSB:0];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_short_word_dropped;
    load_rise && cnt < SER_COUNT |=> !o_wr;
  endproperty
  a_short_word_dropped: assert property (p_short_word_dropped)
    else $error("short serial word was written");

  property p_full_word_written;
    i_enable && armed && load_rise && cnt == SER_COUNT |=> o_wr;
  endproperty
  a_full_word_written: assert property (p_full_word_written)
    else $error("full serial word not written");

  property p_count_capped;
    cnt == SER_COUNT && !load_fall && i_enable |=> cnt == SER_COUNT;
  endproperty
  a_count_capped: assert property (p_count_capped)
    else $error("extra serial clock was counted");

  property p_shift_on_rise;
    armed && sclk_rise && cnt < SER_COUNT && i_enable && !load_rise
      && !load_fall |=> shreg[0] == $past(i_sdata);
  endproperty
  a_shift_on_rise: assert property (p_shift_on_rise)
    else $error("serial bit not captured");
endmodule
`default_nettype wire

/* File: afe_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - New sample on conversion clock falling edge.
// - Upper byte after fall, lower after rise.
// - Latency eight cycles, or six pixel-rotating.
// - Track while clock high, convert while low.
// - Three-channel: sample all, convert red first.
// - Hold input high clamps, low tracks colours.
// - Line sync high: pixel selector back to red, bus released.
// - Line sync low: advance channel on falls.
// - Pixel rotation applies selected channel gain/offset.
// - Serial port live only during line sync.
// - Serial bit captured on shift clock rise.
// - Word written on load strobe rise.
// - Fewer than eleven clocks: nothing written.
// - Clocks beyond eleven are ignored.
// - Three select bits, then eight data bits.
// - Reset gives documented default register values.
// - Power-down keeps registers except signal configuration and top reference.
// - Result bits 15:8 first, MSB on bit 7.
// - Digital reset bit restores all defaults.
module afe_ctrl (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_conv_clock,
  input wire logic i_line_sync,
  input wire logic i_clamp,
  input wire logic [7:0] i_bus_in,
  input wire logic [15:0] i_adc_result,
  output logic [7:0] o_bus_out,
  output logic o_bus_oe,
  output logic o_sample,
  output logic o_track,
  output logic o_rgb_sample,
  output logic o_hold_gb,
  output logic o_clamp_en,
  output logic o_color_track_en,
  output afe_pkg::afe_chan_t o_chan_sel,
  output logic [5:0] o_gain,
  output logic [7:0] o_offset,
  output logic o_power_down,
  output logic o_top_ref_ext,
  output logic o_dc_ref_ext,
  output logic o_ac_coupled,
  output logic o_inverted,
  output afe_pkg::afe_cfg_t o_config
);
  import afe_pkg::*;

  logic [5:0] sync_v;
  logic conv_s;
  logic sync_s;
  logic clamp_s;
  logic ld_s;
  logic sdat_s;
  logic sclk_s;
  logic conv_q;
  logic sync_q;
  logic conv_fall;
  logic conv_rise;
  logic sync_rise;
  logic run_fall;

  logic wr;
  logic [2:0] wsel;
  logic [7:0] wdata;
  logic do_drst;

  logic [7:0] regs [0:NUM_CHAN_REGS-1];
  logic [7:0] mode;
  afe_cfg_t cfg;
  afe_chan_t pix_chan;
  afe_chan_t line_chan;
  afe_chan_t eff_chan;

  logic [15:0] pipe [0:PIPE_DEPTH-1];
  logic [15:0] tap;
  logic [7:0] lo_hold;

  function automatic afe_chan_t next_chan(input afe_chan_t c);
    unique case (c)
      AFE_CH_RED: next_chan = AFE_CH_GRN;
      AFE_CH_GRN: next_chan = AFE_CH_BLU;
      default: next_chan = AFE_CH_RED;
    endcase
  endfunction

  function automatic logic [2:0] tap_index(input afe_cfg_t c);
    unique case (c)
      AFE_CFG_PIX_SINGLE: tap_index = 3'(LAT_PIXEL - 1);
      AFE_CFG_PIX_TRIPLE: tap_index = 3'(LAT_PIXEL - 1);
      AFE_CFG_SINGLE: tap_index = 3'(LAT_LONG - 1);
      AFE_CFG_LINE_TRIPLE: tap_index = 3'(LAT_LONG - 1);
    endcase
  endfunction

  // Pins and the conversion clock come from outside this clock domain
  afe_sync #(
    .WIDTH(6)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_bus_in[7:5], i_clamp, i_line_sync, i_conv_clock}),
    .o_sync(sync_v)
  );

  assign {ld_s, sdat_s, sclk_s, clamp_s, sync_s, conv_s} = sync_v;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      conv_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      conv_q <= conv_s;
      sync_q <= sync_s;
    end
  end

  assign conv_fall = conv_q & ~conv_s;
  assign conv_rise = ~conv_q & conv_s;
  assign sync_rise = ~sync_q & sync_s;
  assign run_fall = conv_fall & ~sync_s;

  afe_serial_load u_serial (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_enable(sync_s),
    .i_load(ld_s),
    .i_sclk(sclk_s),
    .i_sdata(sdat_s),
    .o_wr(wr),
    .o_sel(wsel),
    .o_data(wdata)
  );

  assign do_drst = wr && wsel == SEL_MODE && wdata[MODE_DRST_BIT];
  assign cfg = afe_cfg_t'(mode[MODE_CFG_MSB:MODE_CFG_LSB]);

  // Control registers; select code seven holds test modes, left disabled
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || do_drst) begin
      for (int i = 0; i < NUM_CHAN_REGS; i++) begin
        regs[i] <= i[0] ? OFFS_RST : GAIN_RST;
      end
      mode <= MODE_RST;
    end else if (wr && wsel == SEL_MODE) begin
      if (wdata[MODE_PD_BIT]) begin
        // Configuration fields drop back to defaults while powered down
        mode <= {1'b1, 1'b0, MODE_RST[MODE_TOPREF_BIT],
                 wdata[MODE_DCREF_BIT:MODE_INV_BIT],
                 MODE_RST[MODE_CFG_MSB:MODE_CFG_LSB]};
      end else begin
        mode <= wdata & ~(8'h01 << MODE_DRST_BIT);
      end
    end else if (wr && wsel < SEL_MODE) begin
      regs[wsel] <= wdata;
    end
  end

  // Pixel channel selector
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || sync_s) begin
      pix_chan <= AFE_CH_RED;
    end else if (conv_fall) begin
      pix_chan <= next_chan(pix_chan);
    end
  end

  // Line rotation moves on at each line end, when line sync rises
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || do_drst) begin
      line_chan <= AFE_CH_RED;
    end else if (sync_rise && cfg == AFE_CFG_LINE_TRIPLE) begin
      line_chan <= next_chan(line_chan);
    end
  end

  always_comb begin
    unique case (cfg)
      AFE_CFG_SINGLE: eff_chan = AFE_CH_RED;
      AFE_CFG_LINE_TRIPLE: eff_chan = line_chan;
      AFE_CFG_PIX_SINGLE: eff_chan = pix_chan;
      AFE_CFG_PIX_TRIPLE: eff_chan = pix_chan;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_chan_sel <= AFE_CH_RED;
      o_gain <= GAIN_RST[GAIN_MSB:GAIN_LSB];
      o_offset <= OFFS_RST;
    end else begin
      o_chan_sel <= eff_chan;
      o_gain <= regs[{eff_chan, 1'b0}][GAIN_MSB:GAIN_LSB];
      o_offset <= regs[{eff_chan, 1'b1}];
    end
  end

  // Conversion pipeline, one stage per sampling edge
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe[i] <= 16'h0000;
      end
    end else if (run_fall) begin
      pipe[0] <= i_adc_result;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  assign tap = pipe[tap_index(cfg)];

  // Byte multiplexing onto the shared bus
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_bus_out <= 8'h00;
      lo_hold <= 8'h00;
    end else if (run_fall) begin
      o_bus_out <= tap[15:8];
      lo_hold <= tap[7:0];
    end else if (conv_rise && !sync_s) begin
      o_bus_out <= lo_hold;
    end
  end

  // Bus is released during line sync so the serial pins act as inputs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_bus_oe <= 1'b0;
    end else begin
      o_bus_oe <= !sync_s && !mode[MODE_PD_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sample <= 1'b0;
      o_track <= 1'b0;
      o_rgb_sample <= 1'b0;
      o_hold_gb <= 1'b0;
    end else begin
      o_sample <= run_fall;
      o_track <= conv_s;
      o_rgb_sample <= run_fall && cfg == AFE_CFG_PIX_TRIPLE
                      && pix_chan == AFE_CH_RED;
      o_hold_gb <= cfg == AFE_CFG_PIX_TRIPLE && pix_chan != AFE_CH_RED;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_clamp_en <= 1'b0;
      o_color_track_en <= 1'b1;
    end else begin
      o_clamp_en <= clamp_s;
      o_color_track_en <= !clamp_s;
    end
  end

  assign o_power_down = mode[MODE_PD_BIT];
  assign o_top_ref_ext = mode[MODE_TOPREF_BIT];
  assign o_dc_ref_ext = mode[MODE_DCREF_BIT];
  assign o_ac_coupled = mode[MODE_AC_BIT];
  assign o_inverted = mode[MODE_INV_BIT];
  assign o_config = cfg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_run_fall;
    conv_q && !conv_s && !sync_s;
  endsequence

  sequence s_run_rise;
    !conv_q && conv_s && !sync_s;
  endsequence

  property p_sample_on_fall;
    s_run_fall |=> o_sample && pipe[0] == $past(i_adc_result);
  endproperty
  a_sample_on_fall: assert property (p_sample_on_fall)
    else $error("sample not taken on falling edge");

  property p_upper_byte;
    s_run_fall |=> o_bus_out == $past(tap[15:8]);
  endproperty
  a_upper_byte: assert property (p_upper_byte)
    else $error("upper byte not driven after fall");

  property p_lower_byte;
    s_run_fall ##1 (!conv_fall && !conv_rise)[*1] ##[0:20] s_run_rise
      |=> o_bus_out == $past(lo_hold);
  endproperty
  a_lower_byte: assert property (p_lower_byte)
    else $error("lower byte not driven after rise");

  property p_latency_long;
    s_run_fall ##0 (cfg == AFE_CFG_SINGLE) |=> o_bus_out == $past(pipe[7][15:8]);
  endproperty
  a_latency_long: assert property (p_latency_long)
    else $error("single channel latency wrong");

  property p_latency_pixel;
    s_run_fall ##0 (cfg == AFE_CFG_PIX_TRIPLE)
      |=> o_bus_out == $past(pipe[5][15:8]);
  endproperty
  a_latency_pixel: assert property (p_latency_pixel)
    else $error("pixel rotating latency wrong");

  property p_track_follows_clock;
    conv_s |=> o_track;
  endproperty
  a_track_follows_clock: assert property (p_track_follows_clock)
    else $error("converter not tracking while clock high");

  property p_sync_releases;
    sync_s |=> !o_bus_oe && pix_chan == AFE_CH_RED;
  endproperty
  a_sync_releases: assert property (p_sync_releases)
    else $error("line sync did not release bus");

  property p_advance;
    s_run_fall ##0 (pix_chan == AFE_CH_GRN) |=> pix_chan == AFE_CH_BLU;
  endproperty
  a_advance: assert property (p_advance)
    else $error("channel selector did not advance");

  property p_clamp;
    clamp_s |=> o_clamp_en && !o_color_track_en;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp not enabled");

  property p_digital_reset;
    do_drst |=> mode == MODE_RST && regs[1] == OFFS_RST && regs[0] == GAIN_RST;
  endproperty
  a_digital_reset: assert property (p_digital_reset)
    else $error("digital reset did not restore defaults");

  property p_power_down_cfg;
    wr && wsel == SEL_MODE && wdata[MODE_PD_BIT] && !wdata[MODE_DRST_BIT]
      |=> mode[MODE_PD_BIT] && cfg == AFE_CFG_SINGLE && !o_top_ref_ext;
  endproperty
  a_power_down_cfg: assert property (p_power_down_cfg)
    else $error("power-down kept signal configuration");
endmodule
`default_nettype wire

/* File: afe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module afe_host (
  input wire logic i_clk,
  output logic o_conv_clock,
  output logic o_line_sync,
  output logic o_clamp,
  output logic [7:0] o_bus_drv,
  output logic o_bus_en,
  output logic [15:0] o_adc_result
);
  logic [7:0] k;
  initial begin
    o_conv_clock = 1'b1;
    o_line_sync = 1'b1;
    o_clamp = 1'b0;
    o_bus_drv = 8'h80;
    o_bus_en = 1'b1;
    k = 8'h00;
    o_adc_result = 16'h00FF;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Each result carries its fall count in the upper half, inverted in the lower
  task automatic conv(input logic v);
    o_conv_clock = v;
    if (!v) begin
      k = k + 8'h01;
      o_adc_result = {k, ~k};
    end
  endtask
  task automatic sync(input logic v);
    o_line_sync = v;
    o_bus_en = v;
    w(4);
  endtask
  // Extra clocks beyond the word carry ones
  task automatic send(input logic [10:0] word, input int n);
    o_bus_drv = 8'h00;
    w(4);
    for (int i = 0; i < n; i++) begin
      o_bus_drv[6] = (i < 11) ? word[10 - i] : 1'b1;
      w(4);
      o_bus_drv[5] = 1'b1;
      w(4);
      o_bus_drv[5] = 1'b0;
    end
    w(4);
    o_bus_drv = 8'h80;
    w(6);
  endtask
endmodule
`default_nettype wire

/* File: test_afe_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_afe_ctrl;
  import afe_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic conv, lsync, clamp, hen, oe, track, hold, cl_en, ctrk;
  logic smp, rgb;
  int samples = 0;
  int rgb_samples = 0;
  logic pd, topref, dcref, acc, inv;
  logic tgl = 1'b0;
  logic [7:0] hdrv, bus_out, bus_in, offs;
  logic [15:0] adc;
  logic [5:0] gain;
  logic [6:0] mode;
  afe_chan_t chan;
  afe_cfg_t cfg;
  logic [7:0] ofs [3] = '{8'h10, 8'h20, 8'h30};
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) tgl <= ~tgl;
  // Sampling pulses are counted away from the edge that launches them
  always @(negedge i_clk) begin
    if (smp === 1'b1) samples++;
    if (rgb === 1'b1) rgb_samples++;
  end
  // A bus that neither side drives shows a changing pattern
  assign bus_in = oe ? bus_out : hen ? hdrv : {8{tgl}};
  assign mode = {pd, topref, dcref, acc, inv, cfg};
  afe_host u_afe_host (.i_clk(i_clk), .o_conv_clock(conv),
    .o_line_sync(lsync), .o_clamp(clamp), .o_bus_drv(hdrv),
    .o_bus_en(hen), .o_adc_result(adc));
  afe_ctrl u_afe_ctrl (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_conv_clock(conv), .i_line_sync(lsync), .i_clamp(clamp),
    .i_bus_in(bus_in), .i_adc_result(adc), .o_bus_out(bus_out),
    .o_bus_oe(oe), .o_sample(smp), .o_track(track), .o_rgb_sample(rgb),
    .o_hold_gb(hold), .o_clamp_en(cl_en), .o_color_track_en(ctrk),
    .o_chan_sel(chan), .o_gain(gain), .o_offset(offs),
    .o_power_down(pd), .o_top_ref_ext(topref), .o_dc_ref_ext(dcref),
    .o_ac_coupled(acc), .o_inverted(inv), .o_config(cfg));
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD %0t hang", $time);
      give_verdict;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d, input int n);
    u_afe_host.send({s, d}, n);
  endtask
  // One line of 16 pixels, channel checked per pixel, both bytes once past the latency
  task automatic run(input int lat, input logic [1:0] c);
    logic [7:0] e;
    afe_chan_t h[$];
    int s0;
    int r0;
    e = 8'h00;
    s0 = samples;
    r0 = rgb_samples;
    u_afe_host.sync(1'b0);
    for (int i = 0; i < 16; i++) begin
      u_afe_host.conv(1'b0);
      u_afe_host.w(2);
      if (i > lat) chk(16'({bus_out, track}), 16'({~e, 1'b1}), "lo");
      u_afe_host.w(2);
      u_afe_host.conv(1'b1);
      u_afe_host.w(2);
      e = u_afe_host.k - 8'(lat);
      if (i >= lat) chk(16'({bus_out, track}), 16'({e, 1'b0}), "hi");
      chk(16'({oe, offs}), 16'({1'b1, ofs[chan]}), "ofs");
      h.push_back(chan);
      if (c == 2'h0) chk(16'(chan), 16'h0000, "red");
      else if (c != 2'h3 && i >= 3)
        chk(16'(h[i] === h[i-3] && h[i] !== h[i-1]), 16'h0001, "rot");
      if (c == 2'h2) chk(16'(hold), 16'(chan != AFE_CH_RED), "hold");
      u_afe_host.w(2);
    end
    u_afe_host.sync(1'b1);
    // Line rotation moves on to the next colour as the line ends
    chk(16'({oe, chan}), 16'(c == 2'h3), "sync");
    chk(16'(samples - s0), 16'h0010, "smp");
    chk(16'(rgb_samples - r0), (c == 2'h2) ? 16'h0006 : 16'h0000, "rgb");
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    u_afe_host.w(3);
    chk(16'({gain, offs}), 16'h0040, "rst");
    chk(16'({oe, chan, mode}), 16'h0000, "rstm");
    wr(3'h0, 8'hA8, 11);
    chk(16'(gain), 16'h002A, "gain");
    wr(3'h1, 8'h5C, 11);
    chk(16'(offs), 16'h005C, "offs");
    wr(3'h1, 8'h11, 10);
    chk(16'(offs), 16'h005C, "short");
    wr(3'h0, 8'hFC, 13);
    chk(16'(gain), 16'h003F, "long");
    wr(SEL_MODE, 8'h3D, 11);
    chk(16'(mode), 16'h003D, "mode");
    wr(SEL_MODE, 8'hBD, 11);
    chk(16'({gain, mode}), 16'h1FDC, "pd");
    wr(SEL_MODE, 8'h3D, 11);
    chk(16'(mode), 16'h003D, "wake");
    wr(SEL_MODE, 8'h40, 11);
    chk(16'({gain, offs}), 16'h0040, "drst");
    chk(16'(mode), 16'h0000, "drstm");
    u_afe_host.o_clamp = 1'b1;
    u_afe_host.w(5);
    chk(16'({cl_en, ctrk}), 16'h0002, "clamp");
    u_afe_host.o_clamp = 1'b0;
    u_afe_host.w(5);
    chk(16'({cl_en, ctrk}), 16'h0001, "track");
    for (int i = 0; i < 3; i++) wr(3'(2 * i + 1), ofs[i], 11);
    for (int c = 0; c < 4; c++) begin
      wr(SEL_MODE, 8'(c), 11);
      run((c == 1 || c == 2) ? LAT_PIXEL : LAT_LONG, 2'(c));
    end
    give_verdict;
  end
endmodule
`default_nettype wire
